//--- rtl/external_program_fetch_bus.v
/*
 * external program fetch and data bus sequencer: decodes program space,
 * forms vectors, runs multiplexed bus cycles for fetch, data read, write.
 * assumes a core on the same clock issuing one request at a time and
 * board logic resolving two-way pins from the output enables.
 */
// Notes on behaviour
// - first fetch after reset comes from address 0000H.
// - interrupt vectors at 0003H, 000BH, 0013H, 001BH, eight bytes apart.
// - 4K rom with select high: 0000H-0FFFH internal, above external.
// - 8K rom with select high: 0000H-1FFFH internal, above external.
// - 16K rom with select high: 0000H-3FFFH internal, above external.
// - select low sends every program fetch to external memory.
// - fetch strobe for every external fetch, never for internal ones.
// - low port drives low pc byte, then floats awaiting code byte.
// - latch strobe pulses while low address is valid; latch captures it.
// - high port drives upper pc byte throughout an external fetch.
// - fetch strobe after address phase; memory returns byte; sampled.
// - external program addresses are always full sixteen bits.
// - program space is read-only; no program write cycle exists.
// - both ports are given over to bus use during external fetch.
// - data space separate, up to 64K, own read and write strobes.
// - 16-bit data addresses may come from the data pointer.
// - idle halts core requests while peripherals keep running.
// - power-down, like idle, only blocks new core requests; ram keeps contents.
// - two-byte data address drives its high byte on high port.
`timescale 1ns/1ps
`include "fetch_bus_regs.vh"

module external_program_fetch_bus #(
   parameter [1:0] ROM_SIZE = `ROM_4K
) (
   input  wire        i_core_clk,          // core clock, 50 MHz
   input  wire        i_reset,             // async reset, active high
   input  wire        i_clk_en,            // freezes all state when low
   input  wire        i_external_access_select_n, // strap pin, async
   input  wire        i_req,               // core request, one cycle
   input  wire [1:0]  i_cmd,               // fetch/vector/data rd/data wr
   input  wire [15:0] i_program_counter,   // pc for fetch
   input  wire [1:0]  i_vector_sel,        // which interrupt vector
   input  wire [15:0] i_data_pointer,      // 16-bit data address
   input  wire [7:0]  i_data_addr8,        // 8-bit data address
   input  wire        i_data_wide,         // use data pointer address
   input  wire [7:0]  i_wdata,             // byte to write
   input  wire [7:0]  i_rom_data,          // on-chip rom byte at o_rom_addr
   input  wire        i_idle,              // idle mode request level
   input  wire        i_power_down,        // power-down level
   input  wire [7:0]  i_low_mux_port,      // low port pin level, async
   output reg  [7:0]  o_low_mux_port,      // low port drive value
   output reg         o_low_mux_port_oe,   // low port drive enable
   output reg  [7:0]  o_high_address_port, // high port drive value
   output reg         o_high_address_port_oe, // high port drive enable
   output reg         o_addr_latch_strobe, // latch enable, active high
   output reg         o_program_fetch_strobe_n, // fetch strobe, low
   output reg         o_data_rd_n,         // data read strobe, low
   output reg         o_data_wr_n,         // data write strobe, low
   output reg  [15:0] o_rom_addr,          // on-chip rom address
   output reg  [15:0] o_fetch_addr,        // address of current fetch
   output reg         o_ready,             // can take a request
   output reg         o_done,              // result valid, one cycle
   output reg  [7:0]  o_rdata,             // fetched or read byte
   output reg         o_core_halted        // core held by idle/power-down
);
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_ADDR   = 3'h1;
   localparam [2:0] S_FLOAT  = 3'h2;
   localparam [2:0] S_STROBE = 3'h3;
   localparam [2:0] S_INT    = 3'h4;
   localparam [2:0] S_END    = 3'h5;

   reg  [2:0]  state_q;
   reg  [3:0]  cnt_q;
   reg  [1:0]  kind_q;
   reg         sel_meta_q;
   reg         sel_sync_q;
   reg  [7:0]  port_meta_q;
   reg  [7:0]  port_sync_q;
   reg         first_q;
   reg  [15:0] req_addr;
   wire        internal;

   function [15:0] vector_addr;
      input [1:0] sel;
      begin
         vector_addr = `VEC_EXT_INT0 +
            ({14'h0000, sel} * `VEC_SPACING);
      end
   endfunction

   always @* begin
      case (i_cmd)
         `CMD_VECTOR: req_addr = vector_addr(i_vector_sel);
         `CMD_DATA_RD,
         `CMD_DATA_WR: req_addr = i_data_wide ? i_data_pointer :
                                  {8'h00, i_data_addr8};
         // reset vector fetch first
         // forced here so the rom decode sees the real first address
         default:     req_addr = first_q ? `RESET_VECTOR :
                                 i_program_counter;
      endcase
   end

   rom_space_decode #(
      .ROM_SIZE    (ROM_SIZE)
   ) u_decode (
      .i_addr      (req_addr),
      .i_ext_sel_n (sel_sync_q),
      .o_internal  (internal)
   );

   // strap and bus pins are asynchronous to the core clock
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         sel_meta_q  <= 1'b0;
         sel_sync_q  <= 1'b0;
         port_meta_q <= 8'h00;
         port_sync_q <= 8'h00;
      end else if (i_clk_en) begin
         sel_meta_q  <= i_external_access_select_n;
         sel_sync_q  <= sel_meta_q;
         port_meta_q <= i_low_mux_port;
         port_sync_q <= port_meta_q;
      end
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q                  <= S_IDLE;
         cnt_q                    <= 4'h0;
         kind_q                   <= `CMD_FETCH;
         first_q                  <= 1'b1;
         o_low_mux_port           <= 8'h00;
         o_low_mux_port_oe        <= 1'b0;
         o_high_address_port      <= 8'h00;
         o_high_address_port_oe   <= 1'b0;
         o_addr_latch_strobe      <= 1'b0;
         o_program_fetch_strobe_n <= 1'b1;
         o_data_rd_n              <= 1'b1;
         o_data_wr_n              <= 1'b1;
         o_rom_addr               <= `RESET_VECTOR;
         o_fetch_addr             <= `RESET_VECTOR;
         o_ready                  <= 1'b0;
         o_done                   <= 1'b0;
         o_rdata                  <= 8'h00;
         o_core_halted            <= 1'b0;
      end else if (i_clk_en) begin
         o_done <= 1'b0;
         o_core_halted <= i_idle | i_power_down;
         case (state_q)
            S_IDLE: begin
               o_ready <= ~(i_idle | i_power_down);
               if (i_req && o_ready && !(i_idle | i_power_down)) begin
                  o_ready <= 1'b0;
                  kind_q  <= i_cmd;
                  o_fetch_addr <= req_addr;
                  first_q <= 1'b0;
                  cnt_q   <= 4'h0;
                  if ((i_cmd == `CMD_FETCH || i_cmd == `CMD_VECTOR) &&
                      internal) begin
                     o_rom_addr <= req_addr;
                     state_q <= S_INT;
                  end else begin
                     // both ports owned by the bus
                     o_low_mux_port <= req_addr[7:0];
                     o_low_mux_port_oe   <= 1'b1;
                     o_addr_latch_strobe <= 1'b1;
                     // high address byte (pc or data address) on high port
                     o_high_address_port <= req_addr[15:8];
                     o_high_address_port_oe <= 1'b1;
                     state_q <= S_ADDR;
                  end
               end
            end
            S_ADDR: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == `PH_ADDR_CYCLES - 4'h1) begin
                  // latch strobe falls while address still driven
                  o_addr_latch_strobe <= 1'b0;
                  cnt_q   <= 4'h0;
                  state_q <= S_FLOAT;
               end
            end
            S_FLOAT: begin
               if (kind_q == `CMD_DATA_WR) begin
                  o_low_mux_port <= i_wdata;
                  o_data_wr_n    <= 1'b0;
               end else begin
                  // release low port for the returned byte
                  o_low_mux_port_oe <= 1'b0;
                  o_program_fetch_strobe_n <= (kind_q == `CMD_DATA_RD);
                  o_data_rd_n              <= (kind_q != `CMD_DATA_RD);
               end
               state_q <= S_STROBE;
            end
            S_STROBE: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == `PH_STROBE_CYCLES - 4'h1) begin
                  // strobes never overlap, so board AND is safe
                  if (kind_q != `CMD_DATA_WR)
                     o_rdata <= port_sync_q;
                  o_program_fetch_strobe_n <= 1'b1;
                  o_data_rd_n              <= 1'b1;
                  o_data_wr_n              <= 1'b1;
                  o_low_mux_port_oe        <= 1'b0;
                  o_high_address_port_oe   <= 1'b0;
                  state_q <= S_END;
               end
            end
            S_INT: begin
               // on-chip rom answers one cycle after its address
               o_rdata <= i_rom_data;
               state_q <= S_END;
            end
            S_END: begin
               o_done  <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // external_program_fetch_bus

//--- rtl/fetch_bus_regs.vh
/*
 * constants for the external program fetch and data bus sequencer.
 * assumes inclusion by bare name from rtl files.
 */
`ifndef FETCH_BUS_REGS_VH
`define FETCH_BUS_REGS_VH

`define RESET_VECTOR      16'h0000
`define VEC_EXT_INT0      16'h0003
`define VEC_TIMER0        16'h000B
`define VEC_EXT_INT1      16'h0013
`define VEC_TIMER1        16'h001B
`define VEC_SPACING       16'h0008
`define ROM_NONE          2'h0
`define ROM_4K            2'h1
`define ROM_8K            2'h2
`define ROM_16K           2'h3
`define ROM_TOP_4K        16'h0FFF
`define ROM_TOP_8K        16'h1FFF
`define ROM_TOP_16K       16'h3FFF
`define PH_ADDR_CYCLES    4'h2
`define PH_STROBE_CYCLES  4'h3
`define CMD_FETCH         2'h0
`define CMD_VECTOR        2'h1
`define CMD_DATA_RD       2'h2
`define CMD_DATA_WR       2'h3

`endif

//--- rtl/rom_space_decode.v
/*
 * decides whether a program address is served by on-chip rom.
 * assumes a synchronised select level and a fixed rom size.
 */
`timescale 1ns/1ps
`include "fetch_bus_regs.vh"

module rom_space_decode #(
   parameter [1:0] ROM_SIZE = `ROM_4K
) (
   input  wire [15:0] i_addr,       // program address
   input  wire        i_ext_sel_n,  // synchronised access select
   output reg         o_internal    // 1 = on-chip rom serves it
);
   always @* begin
      if (!i_ext_sel_n) begin
         o_internal = 1'b0;
      end else begin
         case (ROM_SIZE)
            `ROM_4K:  o_internal = (i_addr <= `ROM_TOP_4K);
            `ROM_8K:  o_internal = (i_addr <= `ROM_TOP_8K);
            `ROM_16K: o_internal = (i_addr <= `ROM_TOP_16K);
            default:  o_internal = 1'b0;
         endcase
      end
   end
endmodule // rom_space_decode

//--- tb/ext_mem_model.sv
/* external memory with address latch; code and data share one pattern, last write seen by data reads only.
   assumes the bench resolves the low port from all enables. */
`timescale 1ns/1ps
module ext_mem_model (
   input  wire        i_clk,     // core clock
   input  wire        i_ale,     // latch strobe
   input  wire        i_fetch_n, // fetch strobe
   input  wire        i_rd_n,    // data read strobe
   input  wire        i_wr_n,    // data write strobe
   input  wire [7:0]  i_pins,    // resolved low port
   input  wire [7:0]  i_high,    // high address port
   output logic [7:0] o_drv,     // byte driven back
   output logic       o_drv_en   // drives while high
);
   logic [7:0]  lat_q;
   logic [15:0] wa_q = 16'hFFFF;
   logic [7:0]  wd_q = 8'h00;
   wire  [15:0] addr = {i_high, lat_q};
   wire         rd_n = i_fetch_n & i_rd_n;
   always @(posedge i_clk) if (i_ale) lat_q <= i_pins;
   always @(posedge i_clk) if (!i_wr_n) begin
      wa_q <= addr;
      wd_q <= i_pins;
   end
   assign o_drv_en = !rd_n;
   assign o_drv = (!i_rd_n && addr == wa_q) ? wd_q : i_high ^ lat_q ^ 8'h5A;
endmodule // ext_mem_model

//--- tb/external_program_fetch_bus_tb_top.sv
/* self-checking bench for the fetch bus sequencer, 4K rom build.
   assumes the memory model answers without wait states. */
`timescale 1ns/1ps
module external_program_fetch_bus_tb_top;
   logic clk = 0, rst = 1, req = 0, sel_n = 1, wide = 0, idle = 0, pd = 0;
   logic [1:0] cmd = 0, vsel = 0;
   logic [15:0] pc = 0;
   logic [7:0] wd = 0, prev_q = 0, drv;
   wire [7:0] pins, lo, hi, rdata;
   wire [15:0] rom_a, fa;
   wire lo_oe, ale, fs_n, rd_n, wr_n, done, ready, drv_en, halt;
   int n_errors = 0, check_count = 0, cyc = 0;
   // an undriven port shows a changing pattern, never the last value
   assign pins = lo_oe ? lo : drv_en ? drv : ~prev_q;
   external_program_fetch_bus external_program_fetch_bus_inst (
      .i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
      .i_external_access_select_n(sel_n), .i_req(req), .i_cmd(cmd),
      .i_program_counter(pc), .i_vector_sel(vsel), .i_data_pointer(pc),
      .i_data_addr8(pc[7:0]), .i_data_wide(wide), .i_wdata(wd),
      .i_rom_data(rom_a[7:0] ^ 8'hC3), .i_idle(idle), .i_power_down(pd),
      .i_low_mux_port(pins), .o_low_mux_port(lo), .o_low_mux_port_oe(lo_oe),
      .o_high_address_port(hi), .o_high_address_port_oe(),
      .o_addr_latch_strobe(ale), .o_program_fetch_strobe_n(fs_n),
      .o_data_rd_n(rd_n), .o_data_wr_n(wr_n), .o_rom_addr(rom_a),
      .o_fetch_addr(fa), .o_ready(ready), .o_done(done), .o_rdata(rdata),
      .o_core_halted(halt));
   ext_mem_model ext_mem_model_inst (.i_clk(clk), .i_ale(ale),
      .i_fetch_n(fs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_pins(pins),
      .i_high(hi), .o_drv(drv), .o_drv_en(drv_en));
   task chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task run(logic [1:0] c, logic [15:0] a, logic [7:0] w, int lat,
            logic [7:0] exp, logic ck);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 50) begin
         @(posedge clk); #1; k++;
      end
      @(posedge clk);
      cmd <= c; pc <= a; vsel <= a[1:0]; wd <= w; req <= 1;
      @(posedge clk);
      req <= 0;
      k = 0;
      do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 20);
      chk("latency", lat, k);
      if (ck) chk("rdata", exp, rdata);
   endtask
   task t_reset_fetch;
      run(0, 16'h1234, 0, 2, 8'hC3, 1);
      chk("rom addr", 16'h0000, rom_a);
   endtask
   task t_vectors;
      for (int i = 0; i < 4; i++) begin
         run(1, i, 0, 2, 8'hC3 ^ (8'h03 + 8 * i), 1);
         chk("vector", 16'h0003 + 8 * i, fa);
      end
   endtask
   task t_rom_edge;
      run(0, 16'h0FFF, 0, 2, 8'hFF ^ 8'hC3, 1);
      run(0, 16'h1000, 0, 7, 8'h10 ^ 8'h5A, 1);
      chk("fetch addr", 16'h1000, fa);
   endtask
   task t_data;
      @(posedge clk) wide <= 1;
      run(3, 16'hA55A, 8'h3C, 7, 0, 0);
      run(2, 16'hA55A, 0, 7, 8'h3C, 1);
      run(2, 16'h0102, 0, 7, 8'h01 ^ 8'h02 ^ 8'h5A, 1);
      @(posedge clk) wide <= 0;
      run(2, 16'h0033, 0, 7, 0, 0);
   endtask
   task t_idle_reset;
      @(posedge clk) idle <= 1;
      repeat (2) @(posedge clk);
      #1 chk("halted", 1, halt);
      chk("ready", 0, ready);
      @(posedge clk) idle <= 0;
      pd <= 1;
      repeat (2) @(posedge clk);
      #1 chk("halted", 1, halt);
      chk("ready", 0, ready);
      @(posedge clk) pd <= 0;
      rst <= 1;
      @(posedge clk) rst <= 0;
      repeat (3) @(posedge clk);
      run(0, 16'h0855, 0, 2, 8'hC3, 1);
      chk("rom addr", 16'h0000, rom_a);
   endtask
   task t_strap_low;
      @(posedge clk) sel_n <= 0;
      repeat (3) @(posedge clk);
      run(0, 16'h0100, 0, 7, 8'h01 ^ 8'h5A, 1);
   endtask
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial forever #10 clk = ~clk;
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      t_reset_fetch;
      t_vectors;
      t_rom_edge;
      t_data;
      t_idle_reset;
      t_strap_low;
      give_verdict;
   end
   always @(posedge clk) begin
      prev_q <= pins;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         give_verdict;
      end
   end
endmodule // external_program_fetch_bus_tb_top

//--- tb/fetch_bus_chk.sv
/* bus timing checker for the program fetch and data bus sequencer.
   assumes binding to the sequencer top with port names unchanged. */
`timescale 1ns/1ps
module fetch_bus_chk (
   input wire        i_core_clk,               // core clock
   input wire        i_reset,                  // async reset
   input wire        o_addr_latch_strobe,      // latch strobe
   input wire        o_program_fetch_strobe_n, // fetch strobe
   input wire        o_data_rd_n,              // data read
   input wire        o_data_wr_n,              // data write
   input wire        o_low_mux_port_oe,        // low port enable
   input wire        o_high_address_port_oe,   // high port enable
   input wire [7:0]  o_high_address_port,      // high port value
   input wire [15:0] o_fetch_addr,             // fetch address
   input wire        o_done,                   // answer pulse
   input wire        o_ready                   // idle level
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence ale_pulse;
      o_addr_latch_strobe [*2] ##1 !o_addr_latch_strobe;
   endsequence
   sequence strobe_low;
      !o_program_fetch_strobe_n [*3] ##1 o_program_fetch_strobe_n;
   endsequence
   a_ale_two_cycles: assert property ($rose(o_addr_latch_strobe) |-> ale_pulse)
      else $error("latch strobe width wrong");
   a_ale_addr_valid: assert property (o_addr_latch_strobe |->
      o_low_mux_port_oe && o_high_address_port_oe) else $error("ale off bus");
   a_strobe_after_ale: assert property ($fell(o_program_fetch_strobe_n) |->
      $past(o_addr_latch_strobe, 2) && !o_addr_latch_strobe && !o_low_mux_port_oe)
      else $error("fetch strobe out of order");
   a_strobe_width: assert property ($fell(o_program_fetch_strobe_n) |-> strobe_low)
      else $error("fetch strobe width wrong");
   a_high_port_held: assert property (!o_program_fetch_strobe_n |->
      o_high_address_port_oe && o_high_address_port == o_fetch_addr[15:8])
      else $error("high port lost");
   a_ale_before_float: assert property ($fell(o_low_mux_port_oe) |->
      !o_addr_latch_strobe && !$past(o_addr_latch_strobe)) else $error("float early");
   a_one_strobe_only: assert property ($onehot0({~o_program_fetch_strobe_n,
      ~o_data_rd_n, ~o_data_wr_n})) else $error("strobes overlap");
   a_write_drives: assert property (!o_data_wr_n |-> o_low_mux_port_oe)
      else $error("write data not driven");
   a_done_after_fetch: assert property ($rose(o_program_fetch_strobe_n) |-> ##1 o_done)
      else $error("done late");
   a_ready_after_done: assert property (o_done |=> o_ready) else $error("ready late");
endmodule // fetch_bus_chk
bind external_program_fetch_bus fetch_bus_chk fetch_bus_chk_inst (.*);
